/* File: i2c_host_pkg.sv */
// constants for the i2c host byte engine
// assumes a single 100 MHz clock; the bus wire level is resolved outside
// How it works
// - buffer write sets full flag, starts generator, shifts byte out
// - sda changes after scl falls; scl low one period then high one period
// - eighth falling edge clears full flag and releases sda for acknowledge
// - ninth bit level captured into ack status: low clears, high sets
// - after ninth clock set irq flag, hold scl low until next write
// - write during transmit sets collision flag and is discarded
// - receive enable request ignored unless engine is idle
// - receiving toggles scl each rollover and samples sda per clock
// - after eighth receive clock: clear enable, load buffer, flags, idle
// - receive load sets full flag; buffer read clears it
// - byte received while full flag still set raises overflow flag
// - write during receive sets collision flag and is discarded
// - ack enable pulls scl low and drives ack data bit on sda
// - ack: release scl after period, wait high, period, low, clear, idle
// - write during ack sequence sets collision flag and is discarded
// - stop drives sda low, then scl released, sda released a period later
// - sda high with scl high sets stop seen; period later irq, clear enable
// - software ends with stop or restart; irq only after it completes
// - address byte goes out as seven bits plus direction, then release
// - released scl pauses generator until sampled high, then reload
package i2c_host_pkg;
  localparam logic [7:0] BAUD_RELOAD_RST = 8'h0004;
  localparam logic [3:0] BITS_PER_BYTE = 4'h0008;
  localparam logic [3:0] ACK_BIT_INDEX = 4'h0009;
  localparam logic [7:0] BUFFER_RST = 8'h0000;
  typedef enum logic [7:0] {
    ST_IDLE = 8'b0000_0001,
    ST_TX_LOW = 8'b0000_0010,
    ST_TX_HIGH = 8'b0000_0100,
    ST_RX_LOW = 8'b0000_1000,
    ST_RX_HIGH = 8'b0001_0000,
    ST_ACK_LOW = 8'b0010_0000,
    ST_ACK_HIGH = 8'b0100_0000,
    ST_STOP = 8'b1000_0000
  } engine_state_e;
endpackage

/* File: baud_rate_generator.sv */
// reloadable down counter giving one rollover per reload+1 cycles
// assumes reload value is held stable by software while counting
`timescale 1ns/1ps
module baud_rate_generator (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic reload_i,
  input wire logic [7:0] reload_value_i,
  // status
  output logic rollover_o
);
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  wire at_zero = (count_r == 8'h0000);
  assign count_nxt = (reload_i || !run_i || at_zero) ? reload_value_i
                                                      : count_r - 8'h0001;
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_r <= 8'h0000;
      rollover_o <= 1'b0;
    end else begin
      count_r <= count_nxt;
      rollover_o <= run_i && !reload_i && at_zero;
    end
  end
endmodule

/* File: i2c_host_byte_engine.sv */
// host byte engine: transmit, receive, acknowledge and stop sequences
// assumes start/restart generation lives elsewhere; pins are open drain
`timescale 1ns/1ps
module i2c_host_byte_engine (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // software buffer access
  input wire logic buffer_write_i,
  input wire logic [7:0] buffer_wdata_i,
  input wire logic buffer_read_i,
  output logic [7:0] serial_buffer_o,
  // control requests and configuration
  input wire logic receive_enable_set_i,
  input wire logic ack_sequence_enable_set_i,
  input wire logic ack_data_bit_i,
  input wire logic stop_enable_set_i,
  input wire logic [7:0] baud_reload_value_i,
  // status and flags
  input wire logic irq_flag_clear_i,
  input wire logic write_collision_clear_i,
  input wire logic overflow_clear_i,
  output logic buffer_full_flag_o,
  output logic ack_status_bit_o,
  output logic serial_port_irq_flag_o,
  output logic write_collision_flag_o,
  output logic receive_overflow_flag_o,
  output logic receive_enable_bit_o,
  output logic ack_sequence_enable_o,
  output logic stop_enable_bit_o,
  output logic stop_detected_o,
  output logic engine_idle_o,
  // i2c pins, open drain; enable low means driving low
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o
);
  i2c_host_pkg::engine_state_e state_r;
  i2c_host_pkg::engine_state_e state_nxt;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic [1:0] stop_phase_r;
  logic scl_low_r;
  logic sda_low_r;
  logic scl_low_nxt;
  logic sda_low_nxt;
  logic brg_run;
  logic brg_reload;
  logic rollover;
  logic scl_wait_r;

  baud_rate_generator u_brg (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(brg_run),
    .reload_i(brg_reload),
    .reload_value_i(baud_reload_value_i),
    .rollover_o(rollover)
  );

  wire idle = (state_r == i2c_host_pkg::ST_IDLE);
  // stop phase with scl let go also waits for a stretching client
  wire stop_high = (state_r == i2c_host_pkg::ST_STOP) &&
                   (stop_phase_r == 2'h2);
  wire in_high = (state_r == i2c_host_pkg::ST_TX_HIGH) ||
                 (state_r == i2c_host_pkg::ST_RX_HIGH) ||
                 (state_r == i2c_host_pkg::ST_ACK_HIGH) ||
                 stop_high;
  // released scl must be seen high before the period counts
  wire scl_stretched = in_high && scl_wait_r && !scl_i;
  // stop times its low phase from the moment sda is seen low
  wire stop_reload = (state_r == i2c_host_pkg::ST_STOP) &&
                     (stop_phase_r == 2'h0) && !sda_i;
  assign brg_run = !idle && !scl_stretched;
  assign brg_reload = (in_high && scl_wait_r && scl_i) ||
                      stop_reload;

  // any write outside idle is refused, shift in progress or sequence
  wire wr_ok = buffer_write_i && idle;
  wire wr_collide = buffer_write_i && !idle;
  wire start_rx = receive_enable_set_i && idle && !buffer_write_i;
  wire start_ack = ack_sequence_enable_set_i && idle && !buffer_write_i &&
                   !receive_enable_set_i;
  wire start_stop = stop_enable_set_i && idle && !buffer_write_i &&
                    !receive_enable_set_i && !ack_sequence_enable_set_i;
  wire last_tx_bit = (bit_cnt_r == i2c_host_pkg::ACK_BIT_INDEX);
  wire last_rx_bit = (bit_cnt_r == i2c_host_pkg::BITS_PER_BYTE);
  wire tx_fall = (state_r == i2c_host_pkg::ST_TX_HIGH) && rollover;
  wire rx_fall = (state_r == i2c_host_pkg::ST_RX_HIGH) && rollover;
  wire rx_done = rx_fall && last_rx_bit;
  wire tx_done = tx_fall && last_tx_bit;
  wire tx_eighth_fall = tx_fall && (bit_cnt_r == i2c_host_pkg::BITS_PER_BYTE);
  wire ack_done = (state_r == i2c_host_pkg::ST_ACK_HIGH) && rollover;
  wire stop_seen = (state_r == i2c_host_pkg::ST_STOP) &&
                   (stop_phase_r == 2'h2) && scl_i && sda_i;
  wire stop_done = (state_r == i2c_host_pkg::ST_STOP) &&
                   (stop_phase_r == 2'h3) && rollover;

  always_comb begin
    state_nxt = state_r;
    scl_low_nxt = scl_low_r;
    sda_low_nxt = sda_low_r;
    case (state_r)
      i2c_host_pkg::ST_IDLE: begin
        if (wr_ok) begin
          // first bit is placed while scl is low
          state_nxt = i2c_host_pkg::ST_TX_LOW;
          scl_low_nxt = 1'b1;
          sda_low_nxt = !buffer_wdata_i[7];
        end else if (start_rx) begin
          state_nxt = i2c_host_pkg::ST_RX_LOW;
          scl_low_nxt = 1'b1;
          sda_low_nxt = 1'b0;
        end else if (start_ack) begin
          state_nxt = i2c_host_pkg::ST_ACK_LOW;
          scl_low_nxt = 1'b1;
          sda_low_nxt = !ack_data_bit_i;
        end else if (start_stop) begin
          state_nxt = i2c_host_pkg::ST_STOP;
          scl_low_nxt = 1'b1;
          sda_low_nxt = 1'b1;
        end
      end
      i2c_host_pkg::ST_TX_LOW: begin
        if (rollover) begin
          state_nxt = i2c_host_pkg::ST_TX_HIGH;
          scl_low_nxt = 1'b0;
        end
      end
      i2c_host_pkg::ST_TX_HIGH: begin
        if (tx_done) begin
          state_nxt = i2c_host_pkg::ST_IDLE;
          scl_low_nxt = 1'b1;
        end else if (tx_fall) begin
          state_nxt = i2c_host_pkg::ST_TX_LOW;
          scl_low_nxt = 1'b1;
          // eighth fall releases sda for the client acknowledge
          sda_low_nxt = tx_eighth_fall ? 1'b0 : !shift_r[6];
        end
      end
      i2c_host_pkg::ST_RX_LOW: begin
        if (rollover) begin
          state_nxt = i2c_host_pkg::ST_RX_HIGH;
          scl_low_nxt = 1'b0;
        end
      end
      i2c_host_pkg::ST_RX_HIGH: begin
        if (rx_done) begin
          state_nxt = i2c_host_pkg::ST_IDLE;
          scl_low_nxt = 1'b1;
        end else if (rx_fall) begin
          state_nxt = i2c_host_pkg::ST_RX_LOW;
          scl_low_nxt = 1'b1;
        end
      end
      i2c_host_pkg::ST_ACK_LOW: begin
        if (rollover) begin
          state_nxt = i2c_host_pkg::ST_ACK_HIGH;
          scl_low_nxt = 1'b0;
        end
      end
      i2c_host_pkg::ST_ACK_HIGH: begin
        if (ack_done) begin
          state_nxt = i2c_host_pkg::ST_IDLE;
          scl_low_nxt = 1'b1;
        end
      end
      i2c_host_pkg::ST_STOP: begin
        // phases: wait sda low, count, scl released, sda released
        if (stop_phase_r == 2'h1 && rollover) begin
          scl_low_nxt = 1'b0;
        end else if (stop_phase_r == 2'h2 && rollover) begin
          sda_low_nxt = 1'b0;
        end else if (stop_done) begin
          state_nxt = i2c_host_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = i2c_host_pkg::ST_IDLE;
        scl_low_nxt = 1'b0;
        sda_low_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= i2c_host_pkg::ST_IDLE;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      scl_low_r <= scl_low_nxt;
      sda_low_r <= sda_low_nxt;
    end
  end

  // scl_wait_r marks a high phase still waiting to see scl high
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_wait_r <= 1'b0;
    end else if (!in_high) begin
      scl_wait_r <= 1'b1;
    end else if (scl_i) begin
      scl_wait_r <= 1'b0;
    end
  end

  // stop phase sequencing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_phase_r <= 2'h0;
    end else if (state_r != i2c_host_pkg::ST_STOP) begin
      stop_phase_r <= 2'h0;
    end else if (stop_phase_r == 2'h0 && !sda_i) begin
      stop_phase_r <= 2'h1;
    end else if (stop_phase_r == 2'h1 && rollover) begin
      stop_phase_r <= 2'h2;
    end else if (stop_seen) begin
      stop_phase_r <= 2'h3;
    end
  end

  // shift register and bit counter
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_r <= i2c_host_pkg::BUFFER_RST;
      bit_cnt_r <= 4'h0000;
    end else if (idle) begin
      shift_r <= wr_ok ? buffer_wdata_i : shift_r;
      bit_cnt_r <= 4'h0001;
    end else if (tx_fall) begin
      shift_r <= {shift_r[6:0], 1'b0};
      bit_cnt_r <= bit_cnt_r + 4'h0001;
    end else if ((state_r == i2c_host_pkg::ST_RX_LOW) && rollover) begin
      shift_r <= {shift_r[6:0], sda_i};
    end else if (rx_fall) begin
      bit_cnt_r <= bit_cnt_r + 4'h0001;
    end
  end

  // ack captured at the ninth rising edge
  wire ack_sample = (state_r == i2c_host_pkg::ST_TX_LOW) && rollover &&
                    last_tx_bit;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_buffer_o <= i2c_host_pkg::BUFFER_RST;
      buffer_full_flag_o <= 1'b0;
      ack_status_bit_o <= 1'b0;
    end else begin
      if (wr_ok) begin
        serial_buffer_o <= buffer_wdata_i;
      end else if (rx_done) begin
        serial_buffer_o <= shift_r;
      end
      // set wins over read-clear
      if (wr_ok || rx_done) begin
        buffer_full_flag_o <= 1'b1;
      end else if (tx_eighth_fall || buffer_read_i) begin
        buffer_full_flag_o <= 1'b0;
      end
      if (ack_sample) begin
        ack_status_bit_o <= sda_i;
      end
    end
  end

  // sticky flags: hardware set beats software clear
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      serial_port_irq_flag_o <= 1'b0;
      write_collision_flag_o <= 1'b0;
      receive_overflow_flag_o <= 1'b0;
      stop_detected_o <= 1'b0;
    end else begin
      if (tx_done || rx_done || ack_done || stop_done) begin
        serial_port_irq_flag_o <= 1'b1;
      end else if (irq_flag_clear_i) begin
        serial_port_irq_flag_o <= 1'b0;
      end
      // no self clear; software owns it
      if (wr_collide) begin
        write_collision_flag_o <= 1'b1;
      end else if (write_collision_clear_i) begin
        write_collision_flag_o <= 1'b0;
      end
      if (rx_done && buffer_full_flag_o && !buffer_read_i) begin
        receive_overflow_flag_o <= 1'b1;
      end else if (overflow_clear_i) begin
        receive_overflow_flag_o <= 1'b0;
      end
      if (stop_seen) begin
        stop_detected_o <= 1'b1;
      end else if (wr_ok || start_rx) begin
        stop_detected_o <= 1'b0;
      end
    end
  end

  // enable bits reflect the running sequence
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      receive_enable_bit_o <= 1'b0;
      ack_sequence_enable_o <= 1'b0;
      stop_enable_bit_o <= 1'b0;
      engine_idle_o <= 1'b1;
      scl_o <= 1'b0;
      scl_oe_n_o <= 1'b1;
      sda_o <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      receive_enable_bit_o <= (state_nxt == i2c_host_pkg::ST_RX_LOW) ||
                              (state_nxt == i2c_host_pkg::ST_RX_HIGH);
      ack_sequence_enable_o <= (state_nxt == i2c_host_pkg::ST_ACK_LOW) ||
                               (state_nxt == i2c_host_pkg::ST_ACK_HIGH);
      stop_enable_bit_o <= (state_nxt == i2c_host_pkg::ST_STOP);
      engine_idle_o <= (state_nxt == i2c_host_pkg::ST_IDLE);
      scl_o <= 1'b0;
      scl_oe_n_o <= !scl_low_nxt;
      sda_o <= 1'b0;
      sda_oe_n_o <= !sda_low_nxt;
    end
  end
endmodule

/* File: i2c_host_properties.sv */
// port checker for the i2c host byte engine
// assumes one clock domain; bound to every engine instance
`timescale 1ns/1ps
module i2c_host_checker (
  // watched ports
  input wire logic core_clk_i, rst_i, buffer_write_i, receive_enable_set_i,
  input wire logic ack_data_bit_i, buffer_full_flag_o, ack_status_bit_o,
  input wire logic serial_port_irq_flag_o, write_collision_flag_o,
  input wire logic receive_overflow_flag_o, receive_enable_bit_o,
  input wire logic ack_sequence_enable_o, stop_enable_bit_o, stop_detected_o,
  input wire logic engine_idle_o, scl_i, scl_oe_n_o, sda_i, sda_oe_n_o,
  input wire logic [7:0] buffer_wdata_i, serial_buffer_o
);
  logic tx_r, scl_r, ack_r;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // sda level at the latest scl rise: the ninth one before a tx irq
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_r <= 1'b0;
      scl_r <= 1'b1;
      ack_r <= 1'b1;
    end else begin
      scl_r <= scl_i;
      if (scl_i && !scl_r) ack_r <= sda_i;
      if (buffer_write_i && engine_idle_o) tx_r <= 1'b1;
      else if (serial_port_irq_flag_o) tx_r <= 1'b0;
    end
  end
  busy_write_a: assert property (
    buffer_write_i && !engine_idle_o
    |=> write_collision_flag_o && $stable(serial_buffer_o))
    else $error("busy write not refused");
  write_start_a: assert property (
    buffer_write_i && engine_idle_o
    |=> buffer_full_flag_o && !scl_oe_n_o
    && serial_buffer_o == $past(buffer_wdata_i))
    else $error("write did not start transfer");
  rx_ignored_a: assert property (
    receive_enable_set_i && !engine_idle_o && !receive_enable_bit_o
    |=> !receive_enable_bit_o)
    else $error("receive taken while busy");
  sda_steady_a: assert property (
    scl_i && $past(scl_i) && !stop_enable_bit_o |-> $stable(sda_oe_n_o))
    else $error("sda moved while scl high");
  ack_capture_a: assert property (
    $rose(serial_port_irq_flag_o) && tx_r |-> ack_status_bit_o == ack_r)
    else $error("ack status not ninth bit level");
  tx_suspend_a: assert property (
    $rose(serial_port_irq_flag_o) && tx_r |-> !scl_oe_n_o && engine_idle_o)
    else $error("scl not held low after byte");
  rx_finish_a: assert property (
    $fell(receive_enable_bit_o)
    |-> buffer_full_flag_o && serial_port_irq_flag_o && engine_idle_o
    && !scl_oe_n_o)
    else $error("receive end flags wrong");
  rx_overflow_a: assert property (
    $fell(receive_enable_bit_o) && $past(buffer_full_flag_o)
    |-> receive_overflow_flag_o)
    else $error("overflow not flagged");
  ack_drive_a: assert property (
    $rose(ack_sequence_enable_o)
    |-> !scl_oe_n_o && sda_oe_n_o == $past(ack_data_bit_i))
    else $error("ack level wrong");
  stop_low_a: assert property (
    $rose(stop_enable_bit_o) |-> !sda_oe_n_o)
    else $error("stop did not pull sda");
  stop_seen_a: assert property (
    $rose(stop_detected_o) |-> scl_i && sda_i && stop_enable_bit_o)
    else $error("stop seen without bus high");
endmodule
bind i2c_host_byte_engine i2c_host_checker i_chk (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .buffer_write_i(buffer_write_i),
  .receive_enable_set_i(receive_enable_set_i),
  .ack_data_bit_i(ack_data_bit_i),
  .buffer_full_flag_o(buffer_full_flag_o),
  .ack_status_bit_o(ack_status_bit_o),
  .serial_port_irq_flag_o(serial_port_irq_flag_o),
  .write_collision_flag_o(write_collision_flag_o),
  .receive_overflow_flag_o(receive_overflow_flag_o),
  .receive_enable_bit_o(receive_enable_bit_o),
  .ack_sequence_enable_o(ack_sequence_enable_o),
  .stop_enable_bit_o(stop_enable_bit_o),
  .stop_detected_o(stop_detected_o),
  .engine_idle_o(engine_idle_o),
  .scl_i(scl_i),
  .scl_oe_n_o(scl_oe_n_o),
  .sda_i(sda_i),
  .sda_oe_n_o(sda_oe_n_o),
  .buffer_wdata_i(buffer_wdata_i),
  .serial_buffer_o(serial_buffer_o)
);

/* File: i2c_client_model.sv */
// behavioural i2c client: acks written bytes, sends read bytes, stretches
// assumes wire levels resolved by the bench; pull outputs high = line low
`timescale 1ns/1ps
module i2c_client_model (
  // clock, reset and bus levels
  input wire logic core_clk_i, rst_i, scl_i, sda_i,
  // behaviour selection from the bench
  input wire logic clear_i, tx_mode_i, rx_mode_i, nack_i, stretch_i,
  input wire logic [7:0] rx_byte_i,
  // line pulls and captured byte
  output logic sda_pull_o, scl_pull_o,
  output logic [7:0] seen_o
);
  logic scl_r;
  logic [3:0] rises_r;
  logic [5:0] hold_r;
  logic want;
  assign want = tx_mode_i ? (!nack_i && rises_r == 4'h8) :
    (rx_mode_i && rises_r < 4'h8 && !rx_byte_i[3'h7 - rises_r[2:0]]);
  assign scl_pull_o = hold_r != 6'h00;
  always @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      scl_r <= 1'b1;
      rises_r <= 4'h0;
      hold_r <= 6'h00;
      sda_pull_o <= 1'b0;
      seen_o <= 8'h00;
    end else begin
      scl_r <= scl_i;
      if (clear_i) rises_r <= 4'h0;
      else if (scl_i && !scl_r) begin
        rises_r <= rises_r + 4'h1;
        if (tx_mode_i && rises_r < 4'h8) seen_o <= {seen_o[6:0], sda_i};
      end
      // data only moves while scl is low
      if (!scl_i) sda_pull_o <= want;
      if (stretch_i && !scl_i && scl_r) hold_r <= 6'h28;
      else if (hold_r != 6'h00) hold_r <= hold_r - 6'h01;
    end
  end
endmodule

/* File: testbench.sv */
// self-checking bench for the byte engine with a client model
// assumes pull-ups on both lines; requests driven at falling edges
`timescale 1ns/1ps
module testbench;
  logic core_clk_i = 1'b0, rst_i = 1'b1, ackd = 1'b0, irq_q = 1'b0;
  logic txm = 1'b0, rxm = 1'b0, nk = 1'b0, st = 1'b0, as, fu, ov;
  logic [8:0] rq = 9'h000;
  logic [7:0] wd = 8'h00, rxb = 8'h00, rl = 8'h04, d, lb, bo, seen;
  logic full, acks, irq, write_collision_flag, ovf, rxen, ack_sequence_enable, stopen, stopd, idle;
  logic scl_oe_n, sda_oe_n, spl, cpl;
  wire scl_w = scl_oe_n & !cpl;
  wire sda_w = sda_oe_n & !spl;
  int miscompares = 0, samples_checked = 0, i, seed = 32'hcf7d_d7d6;
  logic [12:0] q[$];
  logic [12:0] ex;
  always #5 core_clk_i = !core_clk_i;
  i2c_host_byte_engine i_i2c_host_byte_engine (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .buffer_write_i(rq[0]), .buffer_wdata_i(wd),
    .buffer_read_i(rq[1]), .serial_buffer_o(bo),
    .receive_enable_set_i(rq[2]), .ack_sequence_enable_set_i(rq[3]),
    .ack_data_bit_i(ackd), .stop_enable_set_i(rq[4]),
    .baud_reload_value_i(rl), .irq_flag_clear_i(rq[5]),
    .write_collision_clear_i(rq[6]), .overflow_clear_i(rq[7]),
    .buffer_full_flag_o(full), .ack_status_bit_o(acks),
    .serial_port_irq_flag_o(irq), .write_collision_flag_o(write_collision_flag),
    .receive_overflow_flag_o(ovf), .receive_enable_bit_o(rxen),
    .ack_sequence_enable_o(ack_sequence_enable), .stop_enable_bit_o(stopen),
    .stop_detected_o(stopd), .engine_idle_o(idle), .scl_i(scl_w),
    .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(),
    .sda_oe_n_o(sda_oe_n));
  i2c_client_model i_i2c_client_model (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .scl_i(scl_w), .sda_i(sda_w), .clear_i(rq[8]),
    .tx_mode_i(txm), .rx_mode_i(rxm), .nack_i(nk), .stretch_i(st),
    .rx_byte_i(rxb), .sda_pull_o(spl), .scl_pull_o(cpl), .seen_o(seen));
  task give_verdict;
    if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [12:0] e, input logic [12:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_bit(input string n, input logic e, input logic g);
    chk(n, {12'h000, e}, {12'h000, g});
  endtask
  task pulse(input logic [8:0] m);
    @(negedge core_clk_i) rq = m;
    @(negedge core_clk_i) rq = 9'h000;
  endtask
  // one sequence: optional busy write plus receive request mid-way
  task op(input logic [8:0] m, input logic c);
    int k;
    q.push_back({1'b0, c, ov, fu, as, lb} | {m[4], 12'h000});
    pulse(9'h100);
    pulse(m);
    if (c) begin
      repeat (3) @(negedge core_clk_i);
      wd = wd ^ 8'hff;
      pulse(9'h005);
      chk("receive_enable", {12'h000, m[2]}, {12'h000, rxen});
    end
    for (k = 0; k < 20000 && irq !== 1'b1; k++) @(negedge core_clk_i);
    if (k >= 20000) begin
      miscompares++;
      give_verdict;
    end
    pulse(9'h020);
    if (c) pulse(9'h040);
  endtask
  // result watcher: every irq rise closes the oldest noted sequence
  always @(negedge core_clk_i) begin
    if (irq === 1'b1 && irq_q !== 1'b1) begin
      if (q.size() == 0) begin
        chk("queue", 13'h0000, 13'h0001);
      end else begin
        ex = q.pop_front();
        chk_bit("stop_detected", ex[12], stopd);
        chk_bit("collision", ex[11], write_collision_flag);
        chk_bit("overflow", ex[10], ovf);
        chk_bit("buffer_full", ex[9], full);
        chk_bit("ack_status", ex[8], acks);
        chk("buffer", {5'h00, ex[7:0]}, {5'h00, bo});
      end
    end
    irq_q = irq;
  end
  initial begin
    ov = 1'b0;
    fu = 1'b0;
    rl = 8'h03 + 8'($random(seed) & 3);
    repeat (16) @(posedge core_clk_i);
    @(negedge core_clk_i) rst_i = 1'b0;
    for (i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      txm = 1'b1;
      rxm = 1'b0;
      nk = i[0];
      st = i[1];
      wd = d;
      as = nk;
      fu = 1'b0;
      lb = d;
      op(9'h001, i == 2);
      chk("client_byte", {5'h00, d}, {5'h00, seen});
    end
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      rxb = d;
      txm = 1'b0;
      rxm = 1'b1;
      st = i[0];
      ov = ov | fu;
      fu = 1'b1;
      lb = d;
      op(9'h004, i == 1);
      if (i != 0) begin
        pulse(9'h002);
        fu = 1'b0;
      end
      if (i == 1) begin
        pulse(9'h080);
        ov = 1'b0;
      end
    end
    rxm = 1'b0;
    for (i = 0; i < 2; i++) begin
      ackd = i[0];
      op(9'h008, i[0]);
    end
    op(9'h010, 1'b1);
    give_verdict;
  end
endmodule
